// >>> design/irqtb_top.sv
// Interrupt request flags, enables, vector selection and time base
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "irqtb_cfg.svh"
module irqtb_top (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // Register port
  input  wire logic [`IRQTB_ADDR_W-1:0]   regAddr,
  input  wire logic [`IRQTB_DATA_W-1:0]   regWrData,
  input  wire logic                       regWrStb,
  input  wire logic                       regRdStb,
  output logic      [`IRQTB_DATA_W-1:0]   regRdData,
  // External interrupt pins
  input  wire logic                       extIrqPinA,
  input  wire logic                       extIrqPinB,
  input  wire logic                       extPinAIsInput,
  input  wire logic                       extPinBIsInput,
  // Peripheral requests
  input  wire logic                       cmpOut,
  input  wire logic                       convDone,
  input  wire logic [2:0]                 serialModuleEvent,
  input  wire logic [5:0]                 serialPortEvent,
  input  wire logic                       lowVoltageDetect,
  input  wire logic                       nvWriteDone,
  input  wire logic [2:0]                 timerMatchP,
  input  wire logic [2:0]                 timerMatchA,
  input  wire logic                       tickInputClock,
  // Core side
  input  wire logic                       stackFull,
  input  wire logic                       returnFromInterrupt,
  output logic                            vecCall,
  output irqtb_pkg::irqtb_vec_t           vecNum,
  output logic                            wakeUp,
  output logic                            slowCrystalLowPower
);
  localparam int NV = `IRQTB_NUM_VEC;
  localparam int NG = `IRQTB_NUM_GSRC;

  logic          globalIrqEnable;
  logic [NV-1:0] vecFlag;
  logic [NV-1:0] vecEnable;
  logic [NG-1:0] srcFlag;
  logic [NG-1:0] srcEnable;
  logic [3:0]    extEdgeSelect;
  logic [7:0]    timeBaseControl;
  logic          pinAPrev;
  logic          pinBPrev;
  logic          cmpPrev;
  logic          tickPrev;
  logic [1:0]    sysDiv;
  logic [NV+NG-1:0] flagsPrev;

  logic [NV-1:0] vecSet;
  logic [NG-1:0] srcSet;
  logic [2:0]    grpSet;
  logic [NV-1:0] fWe;
  logic [NV-1:0] fWd;
  logic [NV-1:0] enWd;
  logic [NV-1:0] pending;
  logic          take;
  irqtb_pkg::irqtb_vec_t pick;
  logic          extAHit;
  logic          extBHit;
  logic          wrCtrl0;
  logic          wrGrp;

  irqtb_tick_if tbIf ();

  ////////////////////////////////////////////////////////////////////
  function automatic logic edgeHit(logic [1:0] mode, logic prev, logic cur);
    case (mode)
      `IRQTB_EDGE_RISE: return !prev & cur;
      `IRQTB_EDGE_FALL: return prev & !cur;
      `IRQTB_EDGE_BOTH: return prev ^ cur;
      default:          return 1'b0;
    endcase
  endfunction : edgeHit

  function automatic irqtb_pkg::irqtb_vec_t firstPending(logic [NV-1:0] p);
    irqtb_pkg::irqtb_vec_t r;
    r = irqtb_pkg::VEC_EXT_A;
    for (int i = NV - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = irqtb_pkg::irqtb_vec_t'(4'(i));
      end
    end
    return r;
  endfunction : firstPending

  // Spreads a register nibble onto the vectors in priority order, save that register 1 puts VEC_TICK_A on bit 3 and VEC_CONV on bit 2; flags take
  // the upper nibble of a control register, enables the nibble below it
  function automatic logic [NV-1:0] vecScatter(logic [3:0] n);
    return {n[3], n[2], n[1], n[0], n[2], n[3], n[1], n[0], n[2], n[1], n[0]};
  endfunction : vecScatter

  ////////////////////////////////////////////////////////////////////
  // Event detection
  assign extAHit = vecEnable[irqtb_pkg::VEC_EXT_A] & extPinAIsInput
                 & edgeHit(extEdgeSelect[1:0], pinAPrev, extIrqPinA);
  assign extBHit = vecEnable[irqtb_pkg::VEC_EXT_B] & extPinBIsInput
                 & edgeHit(extEdgeSelect[3:2], pinBPrev, extIrqPinB);

  // Group sources: timer P/A pairs, then low voltage, then write end
  assign srcSet = {nvWriteDone, lowVoltageDetect, timerMatchA[2], timerMatchP[2],
                   timerMatchA[1], timerMatchP[1], timerMatchA[0], timerMatchP[0]};
  assign grpSet[0] = |(srcSet[1:0] & srcEnable[1:0]);
  assign grpSet[1] = |(srcSet[5:2] & srcEnable[5:2]);
  assign grpSet[2] = |(srcSet[7:6] & srcEnable[7:6]);

  always_comb begin
    vecSet = '0;
    vecSet[irqtb_pkg::VEC_EXT_A]    = extAHit;
    vecSet[irqtb_pkg::VEC_EXT_B]    = extBHit;
    vecSet[irqtb_pkg::VEC_CMP]      = cmpOut ^ cmpPrev;
    vecSet[irqtb_pkg::VEC_MF0]      = grpSet[0];
    vecSet[irqtb_pkg::VEC_MF1]      = grpSet[1];
    vecSet[irqtb_pkg::VEC_MF2]      = grpSet[2];
    vecSet[irqtb_pkg::VEC_CONV]     = convDone;
    vecSet[irqtb_pkg::VEC_TICK_A]   = tbIf.ovfA;
    vecSet[irqtb_pkg::VEC_TICK_B]   = tbIf.ovfB;
    vecSet[irqtb_pkg::VEC_SER_MOD]  = |serialModuleEvent;
    vecSet[irqtb_pkg::VEC_SER_PORT] = |serialPortEvent;
  end

  ////////////////////////////////////////////////////////////////////
  // Software writes to the vectored flags
  assign wrCtrl0 = regWrStb && regAddr == `IRQTB_REG_CTRL0;

  // Control registers 0, 1 and 2 hold vectors 0..2, 3..6 and 7..10: each write covers one run
  assign fWe  = {{4{regWrStb && regAddr == `IRQTB_REG_CTRL2}}, {4{regWrStb && regAddr == `IRQTB_REG_CTRL1}},
                 {3{wrCtrl0}}};
  assign fWd  = vecScatter(regWrData[7:4]);
  // Register 0 keeps the global enable in bit 0, so its enables sit one bit higher
  assign enWd = wrCtrl0 ? vecScatter(regWrData[4:1]) : vecScatter(regWrData[3:0]);

  ////////////////////////////////////////////////////////////////////
  // Vector selection
  assign pending = vecFlag & vecEnable;
  assign take    = globalIrqEnable & |pending & !stackFull;
  assign pick    = firstPending(pending);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vecCall <= 1'b0;
      vecNum  <= irqtb_pkg::VEC_EXT_A;
    end else begin
      vecCall <= take;
      if (take) begin
        vecNum <= pick;
      end
    end
  end

  // A new event in the service cycle wins over the clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vecFlag <= '0;
    end else begin
      for (int i = 0; i < NV; i++) begin
        if (vecSet[i]) begin
          vecFlag[i] <= 1'b1;
        end else if (fWe[i]) begin
          vecFlag[i] <= fWd[i];
        end else if (take && pick == irqtb_pkg::irqtb_vec_t'(4'(i))) begin
          vecFlag[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      globalIrqEnable <= 1'b0;
    end else if (take) begin
      globalIrqEnable <= 1'b0;
    end else if (returnFromInterrupt) begin
      globalIrqEnable <= 1'b1;
    end else if (wrCtrl0) begin
      globalIrqEnable <= regWrData[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enables, group source flags, edge select, time-base control
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vecEnable <= '0;
    end else begin
      vecEnable <= (vecEnable & ~fWe) | (enWd & fWe);
    end
  end

  assign wrGrp = regWrStb && (regAddr == `IRQTB_REG_GRP0 || regAddr == `IRQTB_REG_GRP1
                              || regAddr == `IRQTB_REG_GRP2);

  // Source flags are never cleared by service; software must do it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      srcFlag   <= '0;
      srcEnable <= '0;
    end else begin
      for (int i = 0; i < NG; i++) begin
        if (srcSet[i]) begin
          srcFlag[i] <= 1'b1;
        end else if (wrGrp && regAddr == `IRQTB_REG_GRP0 && i < 2) begin
          srcFlag[i] <= regWrData[4 + i];
        end else if (wrGrp && regAddr == `IRQTB_REG_GRP1 && i >= 2 && i < 6) begin
          srcFlag[i] <= regWrData[2 + i];
        end else if (wrGrp && regAddr == `IRQTB_REG_GRP2 && i >= 6) begin
          srcFlag[i] <= regWrData[i - 2];
        end
      end
      case (regWrStb ? regAddr : `IRQTB_REG_TBC)
        `IRQTB_REG_GRP0: srcEnable[1:0] <= regWrData[1:0];
        `IRQTB_REG_GRP1: srcEnable[5:2] <= regWrData[3:0];
        `IRQTB_REG_GRP2: srcEnable[7:6] <= regWrData[1:0];
        default:         srcEnable      <= srcEnable;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      extEdgeSelect   <= {`IRQTB_EDGE_OFF, `IRQTB_EDGE_OFF};
      timeBaseControl <= `IRQTB_TBC_RESET;
    end else if (regWrStb && regAddr == `IRQTB_REG_EDGE) begin
      extEdgeSelect <= regWrData[3:0];
    end else if (regWrStb && regAddr == `IRQTB_REG_TBC) begin
      timeBaseControl <= regWrData;
    end
  end

  assign slowCrystalLowPower = timeBaseControl[`IRQTB_TBC_LP];

  ////////////////////////////////////////////////////////////////////
  // Previous samples, tick source, wake-up
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinAPrev  <= 1'b0;
      pinBPrev  <= 1'b0;
      cmpPrev   <= 1'b0;
      tickPrev  <= 1'b0;
      sysDiv    <= 2'h0;
      flagsPrev <= '0;
      wakeUp    <= 1'b0;
    end else begin
      pinAPrev  <= extIrqPinA;
      pinBPrev  <= extIrqPinB;
      cmpPrev   <= cmpOut;
      tickPrev  <= tickInputClock;
      sysDiv    <= sysDiv + 2'h1;
      flagsPrev <= {vecFlag, srcFlag};
      wakeUp    <= |({vecFlag, srcFlag} & ~flagsPrev);
    end
  end

  assign tbIf.tick = timeBaseControl[`IRQTB_TBC_CK] ? (sysDiv == `IRQTB_SYSDIV_LAST)
                                                   : (tickInputClock & !tickPrev);
  assign tbIf.run  = timeBaseControl[`IRQTB_TBC_ON];
  assign tbIf.selA = timeBaseControl[`IRQTB_TBC_A_HI:`IRQTB_TBC_A_LO];
  assign tbIf.selB = timeBaseControl[`IRQTB_TBC_B_HI:`IRQTB_TBC_B_LO];

  irqtb_tick_div u_div (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tb      (tbIf.div)
  );

  ////////////////////////////////////////////////////////////////////
  // Read port: data only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= '0;
    end else if (!regRdStb) begin
      regRdData <= '0;
    end else begin
      case (regAddr)
        `IRQTB_REG_CTRL0: regRdData <= {1'b0, vecFlag[irqtb_pkg::VEC_MF0],
          vecFlag[irqtb_pkg::VEC_CMP], vecFlag[irqtb_pkg::VEC_EXT_A],
          vecEnable[irqtb_pkg::VEC_MF0], vecEnable[irqtb_pkg::VEC_CMP],
          vecEnable[irqtb_pkg::VEC_EXT_A], globalIrqEnable};
        `IRQTB_REG_CTRL1: regRdData <= {vecFlag[irqtb_pkg::VEC_TICK_A],
          vecFlag[irqtb_pkg::VEC_CONV], vecFlag[irqtb_pkg::VEC_MF2], vecFlag[irqtb_pkg::VEC_MF1],
          vecEnable[irqtb_pkg::VEC_TICK_A], vecEnable[irqtb_pkg::VEC_CONV],
          vecEnable[irqtb_pkg::VEC_MF2], vecEnable[irqtb_pkg::VEC_MF1]};
        `IRQTB_REG_CTRL2: regRdData <= {vecFlag[irqtb_pkg::VEC_SER_PORT],
          vecFlag[irqtb_pkg::VEC_SER_MOD], vecFlag[irqtb_pkg::VEC_EXT_B],
          vecFlag[irqtb_pkg::VEC_TICK_B], vecEnable[irqtb_pkg::VEC_SER_PORT],
          vecEnable[irqtb_pkg::VEC_SER_MOD], vecEnable[irqtb_pkg::VEC_EXT_B],
          vecEnable[irqtb_pkg::VEC_TICK_B]};
        `IRQTB_REG_GRP0: regRdData <= {2'h0, srcFlag[1:0], 2'h0, srcEnable[1:0]};
        `IRQTB_REG_GRP1: regRdData <= {srcFlag[5:2], srcEnable[5:2]};
        `IRQTB_REG_GRP2: regRdData <= {2'h0, srcFlag[7:6], 2'h0, srcEnable[7:6]};
        `IRQTB_REG_EDGE: regRdData <= {4'h0, extEdgeSelect};
        `IRQTB_REG_TBC:  regRdData <= timeBaseControl;
        default:         regRdData <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence callTaken;
    vecCall;
  endsequence
  sequence callSetup;
    globalIrqEnable && !stackFull && |pending;
  endsequence

  call_needs_ok_a: assert property (callTaken |-> $past(globalIrqEnable) && !$past(stackFull))
    else $error("call taken without enable or stack room");
  call_drops_gie_a: assert property (callSetup |=> callTaken ##0 !globalIrqEnable)
    else $error("service did not clear global enable");
  call_pending_a: assert property (callTaken |-> ($past(vecFlag & vecEnable) & (NV'(1) << vecNum)) != '0)
    else $error("call for a request that was not pending");
  ext_edge_a: assert property (extAHit |=> vecFlag[irqtb_pkg::VEC_EXT_A])
    else $error("external edge did not set flag");
  cmp_change_a: assert property (cmpOut != cmpPrev |=> vecFlag[irqtb_pkg::VEC_CMP])
    else $error("comparator change did not set flag");
  grp_set_a: assert property (grpSet[0] |=> vecFlag[irqtb_pkg::VEC_MF0])
    else $error("group flag not set by enabled source");
  src_kept_a: assert property (callTaken ##0 (vecNum == irqtb_pkg::VEC_MF2)
    |-> srcFlag[7:6] == $past(srcFlag[7:6]) || $past(srcSet[7:6] != 2'h0 || wrGrp))
    else $error("service touched a source flag");
  return_from_interrupt_sets_a: assert property (returnFromInterrupt && !take |=> globalIrqEnable)
    else $error("return did not restore global enable");
  wake_rise_a: assert property (|({vecFlag, srcFlag} & ~flagsPrev) |=> wakeUp)
    else $error("flag rise without wake-up");
  rd_window_a: assert property (!$past(regRdStb) |-> regRdData == '0)
    else $error("read data outside its cycle");
endmodule : irqtb_top

// >>> design/irqtb_cfg.svh
// Register offsets, field positions, reset values and counts of the interrupt block
`ifndef IRQTB_CFG_SVH
`define IRQTB_CFG_SVH

`define IRQTB_ADDR_W      4
`define IRQTB_DATA_W      8
`define IRQTB_REG_CTRL0   4'h0
`define IRQTB_REG_CTRL1   4'h1
`define IRQTB_REG_CTRL2   4'h2
`define IRQTB_REG_GRP0    4'h3
`define IRQTB_REG_GRP1    4'h4
`define IRQTB_REG_GRP2    4'h5
`define IRQTB_REG_EDGE    4'h6
`define IRQTB_REG_TBC     4'h7

`define IRQTB_NUM_VEC     11
`define IRQTB_NUM_GSRC    8

`define IRQTB_TBC_RESET   8'h37
`define IRQTB_TBC_ON      7
`define IRQTB_TBC_CK      6
`define IRQTB_TBC_B_HI    5
`define IRQTB_TBC_B_LO    4
`define IRQTB_TBC_LP      3
`define IRQTB_TBC_A_HI    2
`define IRQTB_TBC_A_LO    0

`define IRQTB_EDGE_OFF    2'h0
`define IRQTB_EDGE_RISE   2'h1
`define IRQTB_EDGE_FALL   2'h2
`define IRQTB_EDGE_BOTH   2'h3

`define IRQTB_TICK_CNT_W  15
`define IRQTB_TICK_A_BASE 8
`define IRQTB_TICK_B_BASE 12
`define IRQTB_SYSDIV_LAST 2'h3

`endif

// >>> design/irqtb_pkg.sv
// Types shared by the interrupt block
package irqtb_pkg;
  // Order is the service priority, first entry highest
  typedef enum logic [3:0] {
    VEC_EXT_A, VEC_CMP, VEC_MF0, VEC_MF1, VEC_MF2, VEC_TICK_A,
    VEC_CONV, VEC_TICK_B, VEC_EXT_B, VEC_SER_MOD, VEC_SER_PORT
  } irqtb_vec_t;
endpackage : irqtb_pkg

// >>> design/irqtb_tick_if.sv
// Carrier between the controller and the time-base divider
`timescale 1ns/1ps
interface irqtb_tick_if;
  logic       tick;
  logic       run;
  logic [2:0] selA;
  logic [1:0] selB;
  logic       ovfA;
  logic       ovfB;
  modport div (input tick, run, selA, selB, output ovfA, ovfB);
  modport ctl (output tick, run, selA, selB, input ovfA, ovfB);
endinterface : irqtb_tick_if

// >>> design/irqtb_tick_div.sv
// Time-base divider producing the two tick overflow pulses
`timescale 1ns/1ps
`include "irqtb_cfg.svh"
module irqtb_tick_div #(
  parameter int CNT_W  = `IRQTB_TICK_CNT_W,
  parameter int A_BASE = `IRQTB_TICK_A_BASE,
  parameter int B_BASE = `IRQTB_TICK_B_BASE
) (
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst_b,
  // Controller side
  irqtb_tick_if.div     tb
);
  logic [CNT_W-1:0] cnt;

  function automatic logic wraps(logic [CNT_W-1:0] c, int bits);
    logic [CNT_W-1:0] mask;
    mask = ~({CNT_W{1'b1}} << bits);
    return (c & mask) == mask;
  endfunction : wraps

  // Held at zero while off so the first period after enable is whole
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (!tb.run) begin
      cnt <= '0;
    end else if (tb.tick) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb.ovfA <= 1'b0;
      tb.ovfB <= 1'b0;
    end else begin
      tb.ovfA <= tb.run & tb.tick & wraps(cnt, A_BASE + int'(tb.selA));
      tb.ovfB <= tb.run & tb.tick & wraps(cnt, B_BASE + int'(tb.selB));
    end
  end

  div_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !tb.run |=> cnt == '0 && !tb.ovfA && !tb.ovfB)
    else $error("divider moved while time base off");
  div_short_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tb.run && tb.tick && tb.selA == 3'h0 && cnt[7:0] == 8'hff |=> tb.ovfA)
    else $error("shortest tick period missed");
endmodule : irqtb_tick_div

// >>> tb/irqtb_core_model.sv
// Core-side model: stack full level and a return shortly after each vectored call
`timescale 1ns/1ps
module irqtb_core_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Bench control
  input  wire logic holdFull,
  // Block side
  input  wire logic vecCall,
  output logic      stackFull,
  output logic      returnFromInterrupt
);
  logic [2:0] retCnt;
  assign stackFull = holdFull;
  ////////////////////////////////////////////////////////////////////////////
  // Short handler so that pending requests chain one after another
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      retCnt              <= 3'h0;
      returnFromInterrupt <= 1'b0;
    end else begin
      returnFromInterrupt <= (retCnt == 3'h1);
      if (vecCall) begin
        retCnt <= 3'h4;
      end else if (retCnt != 3'h0) begin
        retCnt <= retCnt - 3'h1;
      end
    end
  end
endmodule : irqtb_core_model

// >>> tb/tb_irqtb_top.sv
// Self-checking bench of the interrupt block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin nChecks++; if ((got) !== (exp)) begin numErrors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module tb_irqtb_top;
  logic                  ref_clk, rst_b, regWrStb, regRdStb, holdFull;
  logic [3:0]            regAddr;
  logic [7:0]            regWrData, regRdData;
  logic                  extIrqPinA, extIrqPinB, extPinAIsInput, extPinBIsInput, cmpOut;
  logic                  convDone, lowVoltageDetect, nvWriteDone, tickInputClock;
  logic [14:0]           ev;
  logic                  stackFull, returnFromInterrupt, vecCall, wakeUp, slowCrystalLowPower;
  irqtb_pkg::irqtb_vec_t vecNum;
  irqtb_pkg::irqtb_vec_t order[$];
  int                    vcnt[11];
  int                    numErrors, nChecks, cyc, wakeCnt, lastT, prevT, k;
  irqtb_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .extIrqPinA(extIrqPinA),
    .extIrqPinB(extIrqPinB), .extPinAIsInput(extPinAIsInput), .extPinBIsInput(extPinBIsInput),
    .cmpOut(cmpOut), .convDone(convDone), .serialModuleEvent(ev[8:6]), .serialPortEvent(ev[5:0]),
    .lowVoltageDetect(lowVoltageDetect), .nvWriteDone(nvWriteDone), .timerMatchP(ev[11:9]),
    .timerMatchA(ev[14:12]), .tickInputClock(tickInputClock), .stackFull(stackFull),
    .returnFromInterrupt(returnFromInterrupt), .vecCall(vecCall), .vecNum(vecNum), .wakeUp(wakeUp),
    .slowCrystalLowPower(slowCrystalLowPower));
  irqtb_core_model i_core (.ref_clk(ref_clk), .rst_b(rst_b), .holdFull(holdFull), .vecCall(vecCall),
    .stackFull(stackFull), .returnFromInterrupt(returnFromInterrupt));
  ////////////////////////////////////////////////////////////////////////////
  always #10 ref_clk = ~ref_clk;
  // Offset so the tick input never moves on a system clock edge; one rise every three clocks
  initial begin
    tickInputClock = 1'b0;
    #5;
    forever #30 tickInputClock = ~tickInputClock;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (vecCall === 1'b1) begin
      vcnt[vecNum]++;
      order.push_back(vecNum);
      if (vecNum == irqtb_pkg::VEC_TICK_A) begin
        prevT = lastT;
        lastT = cyc;
      end
    end
    if (wakeUp === 1'b1) wakeCnt++;
    if (cyc == 30000) begin
      numErrors++;
      wrapUp();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge ref_clk);
    regWrStb  <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge ref_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    `CHK(nm, exp, regRdData)
  endtask : rdChk
  task automatic wrapUp;
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrapUp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0; rst_b = 1'b0; regWrStb = 1'b0; regRdStb = 1'b0; regAddr = 4'h0; regWrData = 8'h00;
    extIrqPinA = 1'b0; extIrqPinB = 1'b1; extPinAIsInput = 1'b1; extPinBIsInput = 1'b0; cmpOut = 1'b0;
    convDone = 1'b0; lowVoltageDetect = 1'b0; nvWriteDone = 1'b0; ev = 15'h0000; holdFull = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdChk(4'h7, 8'h37, "control reset");
    rdChk(4'h8, 8'h00, "unmapped");
    wr(4'h7, 8'h3F);
    #1 `CHK("low power", 1'b1, slowCrystalLowPower)
    // Requests wait while the stack is full, then go in priority order
    wr(4'h6, 8'h09);
    wr(4'h0, 8'h07);
    @(posedge ref_clk) extIrqPinA <= 1'b1;
    @(posedge ref_clk) cmpOut <= 1'b1;
    repeat (5) @(posedge ref_clk);
    `CHK("calls while full", 0, order.size())
    rdChk(4'h0, 8'h37, "pending flags");
    `CHK("wake pulses", 2, wakeCnt)
    holdFull <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK("first call", irqtb_pkg::VEC_EXT_A, order[0])
    `CHK("second call", irqtb_pkg::VEC_CMP, order[1])
    rdChk(4'h0, 8'h07, "flags served");
    // Edge mode off and pin not an input both ignore the pin
    wr(4'h6, 8'h08);
    @(posedge ref_clk) extIrqPinA <= 1'b0;
    @(posedge ref_clk) extIrqPinA <= 1'b1;
    wr(4'h6, 8'h09);
    @(posedge ref_clk) extPinAIsInput <= 1'b0;
    @(posedge ref_clk) extIrqPinA <= 1'b0;
    @(posedge ref_clk) extIrqPinA <= 1'b1;
    wr(4'h2, 8'h02);
    @(posedge ref_clk) extPinBIsInput <= 1'b1;
    @(posedge ref_clk) extIrqPinB <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK("pin calls", 3, order.size())
    `CHK("falling pin", irqtb_pkg::VEC_EXT_B, order[2])
    wr(4'h1, 8'h04);
    @(posedge ref_clk) convDone <= 1'b1;
    @(posedge ref_clk) convDone <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK("conversion", irqtb_pkg::VEC_CONV, order[3])
    rdChk(4'h1, 8'h04, "conversion served");
    // Every serial and timer event, one at a time
    wr(4'h2, 8'h0E);
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h0F);
    wr(4'h5, 8'h03);
    wr(4'h1, 8'h0F);
    wr(4'h0, 8'h0F);
    for (k = 0; k < 17; k++) begin
      @(posedge ref_clk);
      ev               <= (k < 15) ? 15'h0001 << k : 15'h0000;
      nvWriteDone      <= (k == 15);
      lowVoltageDetect <= (k == 16);
      @(posedge ref_clk);
      ev               <= 15'h0000;
      nvWriteDone      <= 1'b0;
      lowVoltageDetect <= 1'b0;
      repeat (10) @(posedge ref_clk);
    end
    `CHK("port calls", 6, vcnt[irqtb_pkg::VEC_SER_PORT])
    `CHK("module calls", 3, vcnt[irqtb_pkg::VEC_SER_MOD])
    `CHK("group 0 calls", 2, vcnt[irqtb_pkg::VEC_MF0])
    `CHK("group 1 calls", 4, vcnt[irqtb_pkg::VEC_MF1])
    `CHK("group 2 calls", 2, vcnt[irqtb_pkg::VEC_MF2])
    rdChk(4'h3, 8'h33, "group 0 sources");
    rdChk(4'h4, 8'hFF, "group 1 sources");
    rdChk(4'h5, 8'h33, "group 2 sources");
    rdChk(4'h2, 8'h0E, "serial served");
    wr(4'h5, 8'h03);
    rdChk(4'h5, 8'h03, "sources cleared");
    // Time base on system clock over four, shortest first period
    wr(4'h7, 8'hC8);
    for (k = 0; k < 3000 && vcnt[irqtb_pkg::VEC_TICK_A] < 2; k++) @(posedge ref_clk);
    `CHK("tick period", 1024, lastT - prevT)
    wr(4'h7, 8'h48);
    repeat (1100) @(posedge ref_clk);
    `CHK("tick stopped", 2, vcnt[irqtb_pkg::VEC_TICK_A])
    // Dedicated tick input; the second time base wraps with every sixteenth first one
    wr(4'h2, 8'h0F);
    wr(4'h7, 8'h88);
    for (k = 0; k < 13000 && vcnt[irqtb_pkg::VEC_TICK_B] < 1; k++) @(posedge ref_clk);
    `CHK("input tick period", 768, lastT - prevT)
    `CHK("first ticks per second", 18, vcnt[irqtb_pkg::VEC_TICK_A])
    wrapUp();
  end
endmodule : tb_irqtb_top
